// ---- verilog/fccc_defines.vh ----
`ifndef FCCC_DEFINES_VH
`define FCCC_DEFINES_VH
`define FCCC_BASE_BLOCKING 10'h200
`define FCCC_BASE_NONBLOCKING 10'h300
`define FCCC_IDX_COUNT_HIGH 8'hC4
`define FCCC_IDX_COUNT_LOW 8'hC5
`define FCCC_IDX_RUN_FAST 8'hC6
`define FCCC_IDX_WRAP_TOGGLE 8'hC7
`define FCCC_IDX_PIN_ACTION 8'hC8
`define FCCC_IDX_EDGE_SELECT 8'hC9
`define FCCC_IDX_CHANNEL_FLAG 8'hCC
`define FCCC_IDX_WRAP_FLAG 8'hCD
`define FCCC_IDX_VALUE_FIRST 8'hCE
`define FCCC_IDX_VALUE_LAST 8'hD5
`define FCCC_IDX_ACCUM_FIRST 8'hE2
`define FCCC_IDX_ACCUM_LAST 8'hE3
`define FCCC_BIT_RUN 7
`define FCCC_BIT_FAST 4
`define FCCC_BIT_WRAP_FLAG 7
`define FCCC_RESET_BYTE 8'h00
`define FCCC_RESET_NIBBLE 4'h0
`define FCCC_COUNT_ALL_ONES 16'hFFFF
`define FCCC_COUNT_ZERO 16'h0000
`define FCCC_ACT_NONE 2'h0
`define FCCC_ACT_TOGGLE 2'h1
`define FCCC_ACT_CLEAR 2'h2
`define FCCC_ACT_SET 2'h3
`endif

// ---- verilog/fccc_chan.v ----
`timescale 1ns/1ps
`default_nettype none
`include "fccc_defines.vh"
module fccc_chan
(
    input wire pclk,
    input wire presetn,
    input wire run,
    input wire [1:0] action,
    input wire [1:0] edge_sel,
    input wire toggle_on_wrap_bit,
    input wire is_output,
    input wire match,
    input wire force_act,
    input wire wrap,
    input wire pin_in,
    output reg compare_output_line,
    output reg pin_oe_n,
    output reg capture_event
);
    reg pin_meta;
    reg pin_sync;
    reg pin_prev;
    reg next_out;
    wire rise;
    wire fall;
    wire wrap_toggle;

    // Metastability guard: only pin_sync reads pin_meta
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin_meta <= 1'b0;
            pin_sync <= 1'b0;
            pin_prev <= 1'b0;
        end
        else
        begin
            pin_meta <= pin_in;
            pin_sync <= pin_meta;
            pin_prev <= pin_sync;
        end
    end

    assign rise = pin_sync & ~pin_prev;
    assign fall = ~pin_sync & pin_prev;
    assign wrap_toggle = wrap & toggle_on_wrap_bit & is_output;

    always @*
    begin
        next_out = compare_output_line;
        if (wrap_toggle)
        begin
            next_out = ~compare_output_line;
        end
        else if (force_act || match)
        begin
            case (action)
                `FCCC_ACT_TOGGLE: next_out = ~compare_output_line;
                `FCCC_ACT_CLEAR: next_out = 1'b0;
                `FCCC_ACT_SET: next_out = 1'b1;
                default: next_out = compare_output_line;
            endcase
        end
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            compare_output_line <= 1'b0;
            pin_oe_n <= 1'b1;
            capture_event <= 1'b0;
        end
        else
        begin
            compare_output_line <= next_out;
            pin_oe_n <= ~(action[1] | action[0]);
            // Capture only while running, and never on an output channel
            capture_event <= run & ~is_output & ((edge_sel[0] & rise) | (edge_sel[1] & fall));
        end
    end
endmodule
`default_nettype wire

// ---- verilog/fccc_top.v ----
`timescale 1ns/1ps
`default_nettype none
`include "fccc_defines.vh"
module fccc_top
(
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire [15:0] counter_value,
    input wire [3:0] channel_match,
    input wire [3:0] force_compare,
    input wire [3:0] channel_is_output,
    input wire [3:0] timer_channel_pin_in,
    output wire [3:0] compare_output_line,
    output wire [3:0] timer_channel_pin_oe_n,
    output wire [3:0] capture_event,
    output reg timer_run_enable,
    output reg fast_flag_clear_all,
    output reg count_wrap_event,
    output reg [3:0] channel_flag_clear,
    output reg wrap_flag_clear,
    output reg pulse_accum_flag_clear
);
    reg [3:0] wrap_toggle_enables;
    reg [7:0] compare_pin_action;
    reg [7:0] capture_edge_select;
    reg [15:0] count_prev;
    reg wrap_pulse;
    reg [7:0] next_rdata;
    reg next_err;
    reg [3:0] next_chan_clear;
    reg next_wrap_clear;
    reg next_accum_clear;
    wire [9:0] index;
    wire [7:0] offset;
    wire in_window;
    wire access_done;
    wire do_write;
    wire do_read;
    wire is_value;
    wire [2:0] value_pos;
    wire [3:0] value_chan;
    wire is_accum;
    wire is_count;
    wire wrap_now;
    wire [9:0] base_blocking;
    wire [9:0] base_nonblocking;
    wire value_is_output;

    // Byte address is four times the global register index
    assign index = paddr[11:2];
    assign offset = index[7:0];
    assign base_blocking = `FCCC_BASE_BLOCKING;
    assign base_nonblocking = `FCCC_BASE_NONBLOCKING;
    assign in_window = (index[9:8] == base_blocking[9:8])
                     | (index[9:8] == base_nonblocking[9:8]);
    assign access_done = psel & penable & pready;
    assign do_write = access_done & pwrite;
    assign do_read = access_done & ~pwrite;
    assign is_count = (offset == `FCCC_IDX_COUNT_HIGH) | (offset == `FCCC_IDX_COUNT_LOW);
    assign is_value = (offset >= `FCCC_IDX_VALUE_FIRST) & (offset <= `FCCC_IDX_VALUE_LAST);
    assign is_accum = (offset >= `FCCC_IDX_ACCUM_FIRST) & (offset <= `FCCC_IDX_ACCUM_LAST);
    // Two bytes per channel value, channel 3 first
    assign value_pos = offset[3:1] - 3'h7;
    assign value_chan = 4'h8 >> value_pos[1:0];
    assign value_is_output = channel_is_output[value_pos[1:0] ^ 2'h3];

    // Fixed one-wait-state answer
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= psel & penable & ~pready;
            if (psel & penable & ~pready)
            begin
                prdata <= {24'h000000, next_rdata};
                pslverr <= next_err;
            end
        end
    end

    always @*
    begin
        next_rdata = `FCCC_RESET_BYTE;
        next_err = 1'b0;
        if (!in_window)
        begin
            next_err = 1'b1;
        end
        else if (offset == `FCCC_IDX_RUN_FAST)
        begin
            next_rdata = {timer_run_enable, 2'b00, fast_flag_clear_all, 4'h0};
        end
        else if (offset == `FCCC_IDX_WRAP_TOGGLE)
        begin
            next_rdata = {4'h0, wrap_toggle_enables};
        end
        else if (offset == `FCCC_IDX_PIN_ACTION)
        begin
            next_rdata = compare_pin_action;
        end
        else if (offset == `FCCC_IDX_EDGE_SELECT)
        begin
            next_rdata = capture_edge_select;
        end
        else if (offset == `FCCC_IDX_COUNT_HIGH)
        begin
            next_rdata = counter_value[15:8];
        end
        else if (offset == `FCCC_IDX_COUNT_LOW)
        begin
            next_rdata = counter_value[7:0];
        end
        else if (offset == `FCCC_IDX_CHANNEL_FLAG || offset == `FCCC_IDX_WRAP_FLAG)
        begin
            next_rdata = `FCCC_RESET_BYTE;
        end
        else if (is_value || is_accum)
        begin
            next_rdata = `FCCC_RESET_BYTE;
        end
        else
        begin
            next_err = 1'b1;
        end
    end

    // Control registers; writes land at the completing edge
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            timer_run_enable <= 1'b0;
            fast_flag_clear_all <= 1'b0;
            wrap_toggle_enables <= `FCCC_RESET_NIBBLE;
            compare_pin_action <= `FCCC_RESET_BYTE;
            capture_edge_select <= `FCCC_RESET_BYTE;
        end
        else if (do_write && in_window && pstrb[0])
        begin
            if (offset == `FCCC_IDX_RUN_FAST)
            begin
                timer_run_enable <= pwdata[`FCCC_BIT_RUN];
                fast_flag_clear_all <= pwdata[`FCCC_BIT_FAST];
            end
            else if (offset == `FCCC_IDX_WRAP_TOGGLE)
            begin
                wrap_toggle_enables <= pwdata[3:0];
            end
            else if (offset == `FCCC_IDX_PIN_ACTION)
            begin
                compare_pin_action <= pwdata[7:0];
            end
            else if (offset == `FCCC_IDX_EDGE_SELECT)
            begin
                capture_edge_select <= pwdata[7:0];
            end
        end
    end

    // Flag-clear strobes for the flag registers kept elsewhere
    always @*
    begin
        next_chan_clear = 4'h0;
        next_wrap_clear = 1'b0;
        next_accum_clear = 1'b0;
        if (access_done && in_window)
        begin
            if (do_write && pstrb[0] && offset == `FCCC_IDX_CHANNEL_FLAG)
            begin
                next_chan_clear = pwdata[3:0];
            end
            if (do_write && pstrb[0] && offset == `FCCC_IDX_WRAP_FLAG)
            begin
                next_wrap_clear = pwdata[`FCCC_BIT_WRAP_FLAG];
            end
            if (fast_flag_clear_all)
            begin
                // Capture reads and compare writes clear the channel flag
                if (is_value && ((do_read && !value_is_output) || (do_write && value_is_output)))
                begin
                    next_chan_clear = next_chan_clear | value_chan;
                end
                if (is_count)
                begin
                    next_wrap_clear = 1'b1;
                end
                if (is_accum)
                begin
                    next_accum_clear = 1'b1;
                end
            end
        end
    end

    // Wrap seen only while running; counter_value wrapping while stopped raises no event
    assign wrap_now = timer_run_enable & (count_prev == `FCCC_COUNT_ALL_ONES)
                    & (counter_value == `FCCC_COUNT_ZERO);

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            count_prev <= `FCCC_COUNT_ZERO;
            wrap_pulse <= 1'b0;
            count_wrap_event <= 1'b0;
            channel_flag_clear <= 4'h0;
            wrap_flag_clear <= 1'b0;
            pulse_accum_flag_clear <= 1'b0;
        end
        else
        begin
            count_prev <= counter_value;
            wrap_pulse <= wrap_now;
            count_wrap_event <= wrap_now;
            channel_flag_clear <= next_chan_clear;
            wrap_flag_clear <= next_wrap_clear;
            pulse_accum_flag_clear <= next_accum_clear;
        end
    end

    // One channel slice per pin; a stopped timer lets no match through
    fccc_chan u_chan0
    (
        .pclk(pclk),
        .presetn(presetn),
        .run(timer_run_enable),
        .action(compare_pin_action[1:0]),
        .edge_sel(capture_edge_select[1:0]),
        .toggle_on_wrap_bit(wrap_toggle_enables[0]),
        .is_output(channel_is_output[0]),
        .match(channel_match[0] & timer_run_enable),
        .force_act(force_compare[0]),
        .wrap(wrap_pulse),
        .pin_in(timer_channel_pin_in[0]),
        .compare_output_line(compare_output_line[0]),
        .pin_oe_n(timer_channel_pin_oe_n[0]),
        .capture_event(capture_event[0])
    );

    fccc_chan u_chan1
    (
        .pclk(pclk),
        .presetn(presetn),
        .run(timer_run_enable),
        .action(compare_pin_action[3:2]),
        .edge_sel(capture_edge_select[3:2]),
        .toggle_on_wrap_bit(wrap_toggle_enables[1]),
        .is_output(channel_is_output[1]),
        .match(channel_match[1] & timer_run_enable),
        .force_act(force_compare[1]),
        .wrap(wrap_pulse),
        .pin_in(timer_channel_pin_in[1]),
        .compare_output_line(compare_output_line[1]),
        .pin_oe_n(timer_channel_pin_oe_n[1]),
        .capture_event(capture_event[1])
    );

    fccc_chan u_chan2
    (
        .pclk(pclk),
        .presetn(presetn),
        .run(timer_run_enable),
        .action(compare_pin_action[5:4]),
        .edge_sel(capture_edge_select[5:4]),
        .toggle_on_wrap_bit(wrap_toggle_enables[2]),
        .is_output(channel_is_output[2]),
        .match(channel_match[2] & timer_run_enable),
        .force_act(force_compare[2]),
        .wrap(wrap_pulse),
        .pin_in(timer_channel_pin_in[2]),
        .compare_output_line(compare_output_line[2]),
        .pin_oe_n(timer_channel_pin_oe_n[2]),
        .capture_event(capture_event[2])
    );

    fccc_chan u_chan3
    (
        .pclk(pclk),
        .presetn(presetn),
        .run(timer_run_enable),
        .action(compare_pin_action[7:6]),
        .edge_sel(capture_edge_select[7:6]),
        .toggle_on_wrap_bit(wrap_toggle_enables[3]),
        .is_output(channel_is_output[3]),
        .match(channel_match[3] & timer_run_enable),
        .force_act(force_compare[3]),
        .wrap(wrap_pulse),
        .pin_in(timer_channel_pin_in[3]),
        .compare_output_line(compare_output_line[3]),
        .pin_oe_n(timer_channel_pin_oe_n[3]),
        .capture_event(capture_event[3])
    );
endmodule
`default_nettype wire

// ---- verification/fccc_top_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
module fccc_top_assertions
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [15:0] counter_value,
    input wire logic [3:0] channel_match,
    input wire logic [3:0] force_compare,
    input wire logic [3:0] channel_is_output,
    input wire logic [3:0] compare_output_line,
    input wire logic [3:0] capture_event,
    input wire logic timer_run_enable,
    input wire logic fast_flag_clear_all,
    input wire logic count_wrap_event,
    input wire logic [3:0] channel_flag_clear,
    input wire logic wrap_flag_clear
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire wr = psel && penable && pready && pwrite && pstrb[0] && paddr[11];
    // Pin may move one or two cycles after its cause, wrap runs through a flop first
    wire cause = count_wrap_event | (|channel_match) | (|force_compare);
    a_ready_wait: assert property (psel && penable && !pready |=> pready)
        else $error("pready late");
    a_run_write: assert property (wr && paddr[9:2] == 8'hC6 |=> timer_run_enable == $past(pwdata[7]))
        else $error("run bit");
    a_fast_write: assert property (wr && paddr[9:2] == 8'hC6 |=> fast_flag_clear_all == $past(pwdata[4]))
        else $error("fast bit");
    a_wrap_seen: assert property ($past(counter_value) == 16'hFFFF && counter_value == 16'h0000
        && timer_run_enable |=> count_wrap_event)
        else $error("wrap missed");
    a_pin_cause: assert property ($changed(compare_output_line) |-> $past(cause) || $past(cause, 2))
        else $error("pin moved");
    a_capture_input: assert property ((capture_event & $past(channel_is_output)) == 4'h0)
        else $error("capture on output");
    a_unmapped_err: assert property (pready && !paddr[11] |-> pslverr)
        else $error("no slverr");
    a_strobe_cause: assert property ((|channel_flag_clear) || wrap_flag_clear |-> $past(pready))
        else $error("stray strobe");
    c_wrap: cover property (count_wrap_event);
    c_capture: cover property (|capture_event);
    c_error: cover property (pready && pslverr);
endmodule
bind fccc_top fccc_top_assertions u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .pready, .pslverr, .counter_value, .channel_match, .force_compare,
    .channel_is_output, .compare_output_line, .capture_event, .timer_run_enable,
    .fast_flag_clear_all, .count_wrap_event, .channel_flag_clear, .wrap_flag_clear);
`default_nettype wire

// ---- verification/fccc_pin_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module fccc_pin_model
(
    input wire logic [3:0] ext_level,
    input wire logic [3:0] compare_output_line,
    input wire logic [3:0] timer_channel_pin_oe_n,
    output logic [3:0] timer_channel_pin_in
);
    // Outside source yields wherever the channel drives, so no contention is modelled
    assign timer_channel_pin_in = (timer_channel_pin_oe_n & ext_level)
        | (~timer_channel_pin_oe_n & compare_output_line);
endmodule
`default_nettype wire

// ---- verification/fccc_top_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin bad_count++; \
    $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module fccc_top_tb;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, slv;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata;
    logic [3:0] pstrb = '0, channel_match = '0, force_compare = '0, channel_is_output = 4'h1;
    logic [3:0] ext_level = '0, timer_channel_pin_in, compare_output_line, timer_channel_pin_oe_n;
    logic [3:0] capture_event, channel_flag_clear;
    logic [15:0] counter_value = '0;
    logic timer_run_enable, fast_flag_clear_all, count_wrap_event, wrap_flag_clear;
    logic pulse_accum_flag_clear;
    logic [7:0] rd;
    int bad_count = 0, n_checks = 0, i, n;
    // Rows: write, address, data, read value, strobes {channel, wrap, accumulator}
    logic [34:0] rows [0:16] = '{
        {1'b1, 12'hF18, 8'hFF, 8'h00, 6'h00}, {1'b0, 12'hB18, 8'h00, 8'h90, 6'h00},
        {1'b1, 12'hB1C, 8'hFF, 8'h00, 6'h00}, {1'b0, 12'hF1C, 8'h00, 8'h0F, 6'h00},
        {1'b1, 12'hB20, 8'hA5, 8'h00, 6'h00}, {1'b0, 12'hB20, 8'h00, 8'hA5, 6'h00},
        {1'b1, 12'hB24, 8'h3C, 8'h00, 6'h00}, {1'b0, 12'hB24, 8'h00, 8'h3C, 6'h00},
        {1'b1, 12'hB18, 8'h90, 8'h00, 6'h00}, {1'b0, 12'hB10, 8'h00, 8'h00, 6'h02},
        {1'b1, 12'hB88, 8'h00, 8'h00, 6'h01}, {1'b1, 12'hB50, 8'h00, 8'h00, 6'h04},
        {1'b0, 12'hB40, 8'h00, 8'h00, 6'h10},
        {1'b1, 12'hB18, 8'h80, 8'h00, 6'h00}, {1'b0, 12'hB10, 8'h00, 8'h00, 6'h00},
        {1'b1, 12'hB30, 8'h00, 8'h00, 6'h00}, {1'b1, 12'hB30, 8'h05, 8'h00, 6'h14}};
    fccc_top u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
        .pready, .pslverr, .counter_value, .channel_match, .force_compare, .channel_is_output,
        .timer_channel_pin_in, .compare_output_line, .timer_channel_pin_oe_n, .capture_event,
        .timer_run_enable, .fast_flag_clear_all, .count_wrap_event, .channel_flag_clear,
        .wrap_flag_clear, .pulse_accum_flag_clear);
    fccc_pin_model u_pins (.ext_level, .compare_output_line, .timer_channel_pin_oe_n,
        .timer_channel_pin_in);
    initial
    begin
        forever #25 pclk = ~pclk;
    end
    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // Returns one edge after the answer, where the flag-clear strobes stand
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d, input logic [3:0] s);
        int k;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h000000, d};
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge pclk);
            k++;
        end
        while (pready !== 1'b1 && k < 20);
        rd = prdata[7:0];
        slv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k >= 20)
        begin
            bad_count++;
            complete_run();
        end
        @(posedge pclk);
    endtask
    task automatic caps(input logic lvl, output int c);
        ext_level[2] <= lvl;
        c = 0;
        repeat (6)
        begin
            @(posedge pclk);
            if (capture_event[2] === 1'b1)
                c++;
        end
    endtask
    initial
    begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        `CHK(timer_channel_pin_oe_n, 4'hF)
        for (i = 0; i < 4; i++)
        begin
            apb(1'b0, 12'hB18 + 12'(i * 4), 8'h00, 4'h1);
            `CHK(rd, 8'h00)
        end
        for (i = 0; i < 17; i++)
        begin
            apb(rows[i][34], rows[i][33:22], rows[i][21:14], 4'h1);
            `CHK({channel_flag_clear, wrap_flag_clear, pulse_accum_flag_clear}, rows[i][5:0])
            if (!rows[i][34])
                `CHK(rd, rows[i][13:6])
        end
        `CHK({timer_run_enable, fast_flag_clear_all}, 2'b10)
        apb(1'b0, 12'h318, 8'h00, 4'h1);
        `CHK(slv, 1'b1)
        for (i = 0; i < 4; i++)
        begin
            apb(1'b1, 12'hB20, {6'h00, 2'(3 - i)}, 4'h1);
            // Run bit stays set from the table row writing 80 to B18, so each match reaches the channel slice
            channel_match <= 4'h1;
            @(posedge pclk);
            channel_match <= 4'h0;
            repeat (4) @(posedge pclk);
            `CHK(compare_output_line[0], i != 1)
            `CHK(timer_channel_pin_oe_n[0], i == 3)
        end
        apb(1'b1, 12'hB1C, 8'h03, 4'h1);
        apb(1'b1, 12'hB20, 8'h03, 4'h1);
        for (i = 0; i < 2; i++)
        begin
            counter_value <= 16'hFFFF;
            @(posedge pclk);
            counter_value <= 16'h0000;
            @(posedge pclk);
            force_compare <= {3'b000, i == 0};
            @(posedge pclk);
            `CHK(count_wrap_event, 1'b1)
            force_compare <= 4'h0;
            repeat (3) @(posedge pclk);
            `CHK(compare_output_line[0], i == 1)
            `CHK(compare_output_line[1], 1'b0)
        end
        for (i = 0; i < 4; i++)
        begin
            apb(1'b1, 12'hB24, {2'b00, 2'(i), 4'h0}, 4'h1);
            caps(1'b1, n);
            `CHK(n, i % 2)
            caps(1'b0, n);
            `CHK(n, i / 2)
        end
        apb(1'b1, 12'hB18, 8'h00, 4'h1);
        counter_value <= 16'hFFFF;
        @(posedge pclk);
        counter_value <= 16'h0000;
        repeat (2) @(posedge pclk);
        `CHK(count_wrap_event, 1'b0)
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        `CHK({timer_channel_pin_oe_n, compare_output_line}, 8'hF0)
        apb(1'b0, 12'hB1C, 8'h00, 4'h1);
        `CHK(rd, 8'h00)
        complete_run();
    end
endmodule
`default_nettype wire
